// *** hmp_host_port.sv ***
// Host memory port: strobe decoding, address latch, write FIFO and cycle stealing.
`timescale 1ns/100ps
`default_nettype none

// Write buffer between the host strobes and the memory port.
module hmp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count.
    assign o_ready = (count != (PW+1)'(DEPTH));
    assign o_valid = (count != '0);
    assign o_data = mem[rd_ptr];
    assign push = i_valid & o_ready;
    assign pop = o_valid & i_ready;

    // Storage is plain flops written at the tail.
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_data;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

module hmp_host_port (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [2:0] i_boot_mode,
    input wire logic i_port_select_n,
    input wire logic i_address_latch_strobe,
    input wire logic i_host_read_strobe_n,
    input wire logic i_host_write_strobe_n,
    input wire logic [hmp_pkg::HMP_BUS_W-1:0] i_muxed_addr_data,
    output logic [hmp_pkg::HMP_BUS_W-1:0] o_muxed_addr_data,
    output logic o_muxed_addr_data_oe,
    output logic o_host_acknowledge_n,
    input wire logic i_core_reg_wr,
    input wire logic i_core_reg_rd,
    input wire logic [hmp_pkg::HMP_ADDR_W-1:0] i_core_reg_addr,
    input wire logic [hmp_pkg::HMP_BUS_W-1:0] i_core_reg_wdata,
    output logic [hmp_pkg::HMP_BUS_W-1:0] o_core_reg_rdata,
    output logic [hmp_pkg::HMP_BUS_W-1:0] o_overlay_select,
    output logic o_core_halt,
    output logic o_mem_req,
    output logic o_mem_we,
    output logic o_mem_program_store,
    output logic [hmp_pkg::HMP_ADDR_W-1:0] o_mem_addr,
    output logic [hmp_pkg::HMP_PM_W-1:0] o_mem_wdata,
    input wire logic i_mem_grant,
    input wire logic [hmp_pkg::HMP_PM_W-1:0] i_mem_rdata
);
    import hmp_pkg::*;

    hmp_state_t state;
    logic al_q;
    logic rd_q;
    logic wr_q;
    logic [HMP_BUS_W-1:0] bus_q;
    logic al_now;
    logic rd_now;
    logic wr_now;
    logic al_fall;
    logic rd_fall;
    logic wr_rise;
    logic [HMP_BUS_W-1:0] start_addr;
    logic [HMP_BUS_W-1:0] overlay;
    logic [HMP_ADDR_W-1:0] cur_addr;
    logic cur_data_dest;
    logic pm_low_half;
    logic [HMP_BUS_W-1:0] pm_upper;
    logic [HMP_PM_W-1:0] rd_word;
    logic [HMP_BUS_W-1:0] rd_out;
    logic push_pend;
    logic [HMP_ENTRY_W-1:0] push_entry;
    logic push_blocked;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [HMP_ENTRY_W-1:0] fifo_out;
    logic drain;
    logic drain_go;
    logic word_done;
    logic mode_taken;
    logic boot_host;
    logic pm0_written;
    logic [HMP_PM_W-1:0] next_word;

    // Strobes are qualified by select; a latch or data cycle needs select low.
    assign al_now = i_address_latch_strobe & ~i_port_select_n;
    assign rd_now = ~i_host_read_strobe_n & ~i_port_select_n;
    assign wr_now = ~i_host_write_strobe_n & ~i_port_select_n;
    assign al_fall = al_q & ~al_now;
    assign rd_fall = rd_now & ~rd_q & (state == HMP_ST_IDLE);
    assign wr_rise = wr_q & ~wr_now;
    assign cur_addr = start_addr[HMP_ADDR_W-1:0];
    assign cur_data_dest = (start_addr[HMP_DEST_BIT] == HMP_DEST_DATA);

    // One register stage per strobe gives the synchronising cycle.
    // The bus sample of the last cycle is the value present at a strobe edge.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            al_q <= 1'b0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            bus_q <= '0;
        end else begin
            al_q <= al_now;
            rd_q <= rd_now;
            wr_q <= wr_now;
            bus_q <= i_muxed_addr_data;
        end
    end

    // Start address register: host latch first, then core write, then increment.
    // Only bits 0 to 14 are stored, so bit 15 of the latch word never lands here.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            start_addr <= HMP_START_ADDR_RST;
        end else if (al_fall && !bus_q[HMP_SEL_BIT]) begin
            start_addr <= {1'b0, bus_q[HMP_SEL_BIT-1:0]};
        end else if (i_core_reg_wr && i_core_reg_addr == HMP_START_ADDR_OFS) begin
            start_addr <= {1'b0, i_core_reg_wdata[HMP_SEL_BIT-1:0]};
        end else if (word_done) begin
            start_addr <= {start_addr[HMP_BUS_W-1:HMP_ADDR_W], cur_addr + 1'b1};
        end
    end

    // Overlay selection comes from a latch word with bit 15 set or from the core.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            overlay <= HMP_OVERLAY_RST;
        end else if (al_fall && bus_q[HMP_SEL_BIT]) begin
            overlay <= {1'b0, bus_q[HMP_SEL_BIT-1:0]};
        end else if (i_core_reg_wr && i_core_reg_addr == HMP_OVERLAY_OFS) begin
            overlay <= i_core_reg_wdata;
        end
    end

    assign o_overlay_select = overlay;

    // Core reads of the two registers; the host can load these through a latch word but cannot read them.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_core_reg_rdata <= '0;
        end else if (i_core_reg_rd) begin
            unique case (i_core_reg_addr)
                HMP_START_ADDR_OFS: o_core_reg_rdata <= start_addr;
                HMP_OVERLAY_OFS: o_core_reg_rdata <= overlay;
                default: o_core_reg_rdata <= '0;
            endcase
        end
    end

    // A program word moves as two bus words: upper 16 bits, then the low byte.
    // A new address from either side restarts at the upper half.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pm_low_half <= 1'b0;
            pm_upper <= '0;
        end else if (al_fall || (i_core_reg_wr && i_core_reg_addr == HMP_START_ADDR_OFS)) begin
            pm_low_half <= 1'b0;
        end else if (!cur_data_dest) begin
            if (wr_rise) begin
                pm_low_half <= ~pm_low_half;
                if (!pm_low_half) begin
                    pm_upper <= bus_q;
                end
            end else if (rd_fall && pm_low_half) begin
                pm_low_half <= 1'b0;
            end else if (state == HMP_ST_CAPT) begin
                pm_low_half <= 1'b1;
            end
        end
    end

    // A completed write word, data words zero-filled in the upper byte.
    always_comb begin
        next_word = {8'h00, bus_q};
        if (!cur_data_dest) begin
            next_word = {pm_upper, bus_q[HMP_LOW_BYTE_W-1:0]};
        end
    end

    // Completed write words wait at least one cycle, then enter the FIFO once it has room.
    // Writes into the control register window are dropped but still advance the address.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            push_pend <= 1'b0;
            push_entry <= '0;
            push_blocked <= 1'b0;
        end else if (wr_rise && (cur_data_dest || pm_low_half)) begin
            push_pend <= 1'b1;
            push_entry <= {~cur_data_dest, cur_addr, next_word};
            push_blocked <= cur_data_dest && (cur_addr >= HMP_CTRL_BASE);
        end else if (push_pend && (fifo_in_ready || push_blocked)) begin
            push_pend <= 1'b0;
        end
    end

    hmp_fifo #(
        .WIDTH(HMP_ENTRY_W),
        .DEPTH(HMP_FIFO_DEPTH)
    ) u_wr_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_valid(push_pend & ~push_blocked),
        .o_ready(fifo_in_ready),
        .i_data(push_entry),
        .o_valid(fifo_out_valid),
        .i_ready(drain_go),
        .o_data(fifo_out)
    );

    // The address advances once per finished word, written or read.
    assign word_done = (push_pend && (fifo_in_ready || push_blocked))
        || (state == HMP_ST_CAPT && cur_data_dest)
        || (rd_fall && pm_low_half && !cur_data_dest);

    // Read sequence: sync, wait for buffered writes to drain, access, capture.
    // Draining first keeps a read from overtaking an earlier write to the same word.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= HMP_ST_IDLE;
        end else begin
            unique case (state)
                HMP_ST_IDLE: begin
                    if (rd_fall && (cur_data_dest || !pm_low_half)) begin
                        state <= HMP_ST_SYNC;
                    end
                end
                HMP_ST_SYNC: begin
                    if (!fifo_out_valid && !push_pend) begin
                        state <= HMP_ST_READ;
                    end
                end
                HMP_ST_READ: begin
                    if (i_mem_grant) begin
                        state <= HMP_ST_CAPT;
                    end
                end
                HMP_ST_CAPT: begin
                    state <= HMP_ST_IDLE;
                end
            endcase
        end
    end

    // Memory returns read data the cycle after the grant.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rd_word <= '0;
            rd_out <= '0;
        end else if (state == HMP_ST_CAPT) begin
            rd_word <= i_mem_rdata;
            rd_out <= cur_data_dest ? i_mem_rdata[HMP_BUS_W-1:0]
                : i_mem_rdata[HMP_PM_W-1:HMP_LOW_BYTE_W];
        end else if (rd_fall && pm_low_half && !cur_data_dest) begin
            rd_out <= {8'h00, rd_word[HMP_LOW_BYTE_W-1:0]};
        end
    end

    // Only memory contents ever go out on the bus, never the latched address.
    assign o_muxed_addr_data = rd_out;
    assign o_muxed_addr_data_oe = rd_now;

    // Buffered writes drain whenever no read owns the memory port.
    // Each request is held until the core grants one cycle for it.
    assign drain = fifo_out_valid && (state != HMP_ST_READ) && (state != HMP_ST_CAPT);
    assign drain_go = drain & i_mem_grant;
    assign o_mem_req = drain || (state == HMP_ST_READ);
    assign o_mem_we = drain;
    assign o_mem_program_store = drain ? fifo_out[HMP_ENTRY_W-1] : ~cur_data_dest;
    assign o_mem_addr = drain ? fifo_out[HMP_ENTRY_W-2:HMP_PM_W] : cur_addr;
    assign o_mem_wdata = fifo_out[HMP_PM_W-1:0];

    // Acknowledge is low only when a latch or data strobe can be taken at once.
    // The host relies on it before every operation and after every data transfer.
    assign o_host_acknowledge_n = (state != HMP_ST_IDLE) || push_pend
        || !fifo_in_ready || rd_fall;

    // Boot straps are caught in the first cycle after reset release.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mode_taken <= 1'b0;
            boot_host <= 1'b0;
        end else if (!mode_taken) begin
            mode_taken <= 1'b1;
            boot_host <= (i_boot_mode == HMP_BOOT_HOST);
        end
    end

    // In host boot, execution stays held until the host writes program location zero.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pm0_written <= 1'b0;
        end else if (drain_go && fifo_out[HMP_ENTRY_W-1]
                && fifo_out[HMP_ENTRY_W-2:HMP_PM_W] == HMP_BOOT_ADDR) begin
            pm0_written <= 1'b1;
        end
    end

    // Held in reset and in the strap cycle so the core never starts too early.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_core_halt <= 1'b1;
        end else begin
            o_core_halt <= !mode_taken || (boot_host && !pm0_written);
        end
    end
endmodule

`default_nettype wire

// *** hmp_pkg.sv ***
// Constants, register map and state encoding for the host memory port.
package hmp_pkg;
    // Widths of the multiplexed bus, the on-chip address and the stored words.
    localparam int HMP_BUS_W = 16;
    localparam int HMP_ADDR_W = 14;
    localparam int HMP_PM_W = 24;
    localparam int HMP_ENTRY_W = 1 + HMP_ADDR_W + HMP_PM_W;
    localparam int HMP_FIFO_DEPTH = 8;
    // Core-side register map; control registers start at the base.
    localparam logic [13:0] HMP_CTRL_BASE = 14'h3FE0;
    localparam logic [13:0] HMP_START_ADDR_OFS = HMP_CTRL_BASE;
    localparam logic [13:0] HMP_OVERLAY_OFS = 14'h3FE7;
    localparam logic [15:0] HMP_START_ADDR_RST = 16'h0000;
    localparam logic [15:0] HMP_OVERLAY_RST = 16'h0000;
    // Field positions in an address latch word and the start address register.
    localparam int HMP_SEL_BIT = 15;
    localparam int HMP_DEST_BIT = 14;
    localparam int HMP_LOW_BYTE_W = 8;
    localparam logic HMP_DEST_DATA = 1'b1;
    localparam logic [13:0] HMP_BOOT_ADDR = 14'h0000;
    // Boot straps ordered C, B, A.
    localparam logic [2:0] HMP_BOOT_HOST = 3'b101;
    typedef enum logic [1:0] {
        HMP_ST_IDLE = 2'b00,
        HMP_ST_SYNC = 2'b01,
        HMP_ST_READ = 2'b10,
        HMP_ST_CAPT = 2'b11
    } hmp_state_t;
endpackage

// *** hmp_checker.sv ***
// Port assertions for the host memory port.
`timescale 1ns/100ps
`default_nettype none
module hmp_checker (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_port_select_n,
    input wire logic i_address_latch_strobe,
    input wire logic i_host_read_strobe_n,
    input wire logic [hmp_pkg::HMP_BUS_W-1:0] i_muxed_addr_data,
    input wire logic o_muxed_addr_data_oe,
    input wire logic o_host_acknowledge_n,
    input wire logic i_core_reg_wr,
    input wire logic i_core_reg_rd,
    input wire logic [hmp_pkg::HMP_ADDR_W-1:0] i_core_reg_addr,
    input wire logic [hmp_pkg::HMP_BUS_W-1:0] i_core_reg_wdata,
    input wire logic [hmp_pkg::HMP_BUS_W-1:0] o_core_reg_rdata,
    input wire logic [hmp_pkg::HMP_BUS_W-1:0] o_overlay_select,
    input wire logic o_core_halt,
    input wire logic o_mem_req,
    input wire logic o_mem_we,
    input wire logic o_mem_program_store,
    input wire logic [hmp_pkg::HMP_ADDR_W-1:0] o_mem_addr,
    input wire logic i_mem_grant
);
    import hmp_pkg::*;
    // All checks share the core clock and are quiet during reset.
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_rd_ack;
        o_mem_req && !o_mem_we |-> o_host_acknowledge_n;
    endproperty
    a_rd_ack: assert property (p_rd_ack) else $error("ack shown during read");
    property p_req_hold;
        o_mem_req && !i_mem_grant |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped");
    property p_ctrl_guard;
        o_mem_req && o_mem_we && !o_mem_program_store |-> o_mem_addr < HMP_CTRL_BASE;
    endproperty
    a_ctrl_guard: assert property (p_ctrl_guard) else $error("control write");
    property p_ovl_latch;
        $past(i_address_latch_strobe) && !$past(i_port_select_n) && !i_address_latch_strobe
            && $past(i_muxed_addr_data[15])
            |=> o_overlay_select[14:0] == $past(i_muxed_addr_data[14:0], 2);
    endproperty
    a_ovl_latch: assert property (p_ovl_latch) else $error("overlay latch");
    property p_oe;
        o_muxed_addr_data_oe |-> !i_host_read_strobe_n && !i_port_select_n;
    endproperty
    a_oe: assert property (p_oe) else $error("bus driven without read");
    // Sync takes one whole cycle, so no read cycle in the strobe cycle or the next.
    property p_sync;
        $fell(i_host_read_strobe_n) && !i_port_select_n
            |-> !(o_mem_req && !o_mem_we) ##1 !(o_mem_req && !o_mem_we);
    endproperty
    a_sync: assert property (p_sync) else $error("read not synchronised");
    property p_halt;
        o_core_halt && i_mem_grant && o_mem_we && o_mem_program_store
            && o_mem_addr == HMP_BOOT_ADDR |-> ##[1:2] !o_core_halt;
    endproperty
    a_halt: assert property (p_halt) else $error("halt kept");
    property p_core_ovl;
        i_core_reg_wr && i_core_reg_addr == HMP_OVERLAY_OFS && !$past(i_address_latch_strobe)
            |=> o_overlay_select == $past(i_core_reg_wdata);
    endproperty
    a_core_ovl: assert property (p_core_ovl) else $error("overlay write");
    property p_core_rd;
        i_core_reg_rd && i_core_reg_addr == HMP_OVERLAY_OFS
            |=> o_core_reg_rdata == $past(o_overlay_select);
    endproperty
    a_core_rd: assert property (p_core_rd) else $error("overlay read");
endmodule
bind hmp_host_port hmp_checker hmp_checker_i (.i_clk, .i_rst, .i_port_select_n,
    .i_address_latch_strobe, .i_host_read_strobe_n, .i_muxed_addr_data,
    .o_muxed_addr_data_oe, .o_host_acknowledge_n, .i_core_reg_wr, .i_core_reg_rd,
    .i_core_reg_addr, .i_core_reg_wdata, .o_core_reg_rdata, .o_overlay_select,
    .o_core_halt, .o_mem_req, .o_mem_we, .o_mem_program_store, .o_mem_addr, .i_mem_grant);
`default_nettype wire

// *** hmp_host_model.sv ***
// Host side model: strobes, bus drive and acknowledge polling.
`timescale 1ns/100ps
`default_nettype none
module hmp_host_model (
    input wire logic i_clk,
    input wire logic i_ack_n,
    input wire logic i_oe,
    input wire logic [15:0] i_dout,
    output logic o_sel_n,
    output logic o_als,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic [15:0] o_bus
);
    logic [15:0] drv;
    int n_late = 0;
    // The device wins the bus while it reads out; a released host bus shows inverted data.
    assign o_bus = i_oe ? i_dout : drv;
    initial {o_sel_n, o_als, o_rd_n, o_wr_n, drv} = {4'hB, 16'h0000};
    // Polls off the edge so the combinational acknowledge has settled.
    task automatic wait_ack();
        int n;
        n = 0;
        #1;
        while (i_ack_n !== 1'b0 && n < 200) begin
            @(posedge i_clk);
            #1 n++;
        end
        if (n == 200) n_late++;
    endtask
    task automatic latch(input logic [15:0] v);
        wait_ack();
        @(posedge i_clk);
        {o_sel_n, o_als} <= 2'h1;
        drv <= v;
        @(posedge i_clk);
        {o_sel_n, o_als} <= 2'h2;
        @(posedge i_clk);
        drv <= ~v;
    endtask
    // Strobes stay put until acknowledge shows the word done.
    task automatic xfer(input logic wr, input logic [15:0] v, output logic [15:0] d);
        wait_ack();
        @(posedge i_clk);
        o_sel_n <= 1'b0;
        o_wr_n <= !wr;
        o_rd_n <= wr;
        if (wr) drv <= v;
        repeat (3) @(posedge i_clk);
        wait_ack();
        d = o_bus;
        @(posedge i_clk);
        {o_sel_n, o_rd_n, o_wr_n} <= 3'h7;
        drv <= ~drv;
        repeat (2) @(posedge i_clk);
    endtask
    task automatic write(input logic [15:0] v);
        logic [15:0] d;
        xfer(1'b1, v, d);
    endtask
endmodule
`default_nettype wire

// *** hmp_host_port_tb.sv ***
// Self-checking bench for the host memory port.
`timescale 1ns/100ps
`default_nettype none
module hmp_host_port_tb;
    import hmp_pkg::*;
    logic clk = 1'b0, rst, stall, reg_wr, reg_rd;
    logic [2:0] boot;
    logic [13:0] reg_addr, mem_addr;
    logic [15:0] reg_wdata, reg_rdata, ovl, dout, bus;
    logic [23:0] mem_rdata, mem_wdata, mem [0:32767];
    logic sel_n, als, rd_n, wr_n, oe, ack_n, halt, mem_req, mem_we, mem_ps, mem_grant;
    int n_errors = 0, samples_checked = 0, n_wr = 0;
    always #5 clk = ~clk;
    hmp_host_port hmp_host_port_i (.i_clk(clk), .i_rst(rst), .i_boot_mode(boot),
        .i_port_select_n(sel_n), .i_address_latch_strobe(als), .i_host_read_strobe_n(rd_n),
        .i_host_write_strobe_n(wr_n), .i_muxed_addr_data(bus), .o_muxed_addr_data(dout),
        .o_muxed_addr_data_oe(oe), .o_host_acknowledge_n(ack_n), .i_core_reg_wr(reg_wr),
        .i_core_reg_rd(reg_rd), .i_core_reg_addr(reg_addr), .i_core_reg_wdata(reg_wdata),
        .o_core_reg_rdata(reg_rdata), .o_overlay_select(ovl), .o_core_halt(halt),
        .o_mem_req(mem_req), .o_mem_we(mem_we), .o_mem_program_store(mem_ps),
        .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata), .i_mem_grant(mem_grant),
        .i_mem_rdata(mem_rdata));
    hmp_host_model hmp_host_model_i (.i_clk(clk), .i_ack_n(ack_n), .i_oe(oe), .i_dout(dout),
        .o_sel_n(sel_n), .o_als(als), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_bus(bus));
    // Core memory grants at once unless stalled; read data follows one cycle later.
    assign mem_grant = mem_req & ~stall;
    always @(posedge clk) begin
        if (mem_grant && mem_we) begin
            mem[{mem_ps, mem_addr}] <= mem_wdata;
            n_wr <= n_wr + 1;
        end
        mem_rdata <= mem[{mem_ps, mem_addr}];
    end
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic core_rd(input logic [13:0] a, output logic [15:0] d);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic hread(output logic [15:0] d);
        hmp_host_model_i.xfer(1'b0, 16'h0000, d);
    endtask
    task automatic t_boot();
        logic [15:0] d;
        check("halt", 1, halt);
        hmp_host_model_i.latch(16'h0000);
        hmp_host_model_i.write(16'hABCD);
        hmp_host_model_i.write(16'h00EF);
        repeat (6) @(posedge clk);
        check("pm word", 24'hABCDEF, mem[15'h4000]);
        check("halt", 0, halt);
        hmp_host_model_i.latch(16'h0000);
        hread(d);
        check("pm high", 16'hABCD, d);
        hread(d);
        check("pm low", 16'h00EF, d);
        $display("t_boot done");
    endtask
    task automatic t_regs();
        logic [15:0] d;
        core_rd(HMP_OVERLAY_OFS, d);
        check("overlay reset", HMP_OVERLAY_RST, d);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, HMP_OVERLAY_OFS, 16'h0002};
        @(posedge clk);
        reg_wr <= 1'b0;
        core_rd(HMP_OVERLAY_OFS, d);
        check("overlay rw", 16'h0002, d);
        core_rd(14'h3FE5, d);
        check("unmapped", 16'h0000, d);
        $display("t_regs done");
    endtask
    task automatic t_dm();
        logic [15:0] d;
        hmp_host_model_i.latch(16'h4100);
        for (int i = 0; i < 3; i++) hmp_host_model_i.write(16'h1111 * (i + 1));
        core_rd(HMP_START_ADDR_OFS, d);
        check("start addr", 16'h4103, d);
        for (int i = 0; i < 3; i++) check("dm word", 16'h1111 * (i + 1), mem[15'h0100 + i]);
        hmp_host_model_i.latch(16'h4101);
        hread(d);
        check("dm read", 16'h2222, d);
        $display("t_dm done");
    endtask
    task automatic t_ctrl();
        logic [15:0] d;
        int n;
        n = n_wr;
        hmp_host_model_i.latch(16'h7FE0);
        hmp_host_model_i.write(16'h1234);
        repeat (6) @(posedge clk);
        check("ctrl writes", n, n_wr);
        hmp_host_model_i.latch(16'h8005);
        #1 check("overlay latch", 16'h0005, ovl);
        core_rd(HMP_START_ADDR_OFS, d);
        check("start kept", 16'h7FE1, d);
        $display("t_ctrl done");
    endtask
    // Memory stalls so the buffer fills; acknowledge must then hold off the host.
    task automatic t_fifo();
        int n;
        n = n_wr;
        stall <= 1'b1;
        hmp_host_model_i.latch(16'h4200);
        for (int i = 0; i < 8; i++) hmp_host_model_i.write(16'hA000 + i);
        #1 check("ack full", 1, ack_n);
        check("stalled", n, n_wr);
        stall <= 1'b0;
        repeat (20) @(posedge clk);
        for (int i = 0; i < 8; i++) check("drained", 16'hA000 + i, mem[15'h0200 + i]);
        $display("t_fifo done");
    endtask
    // A second reset with straps that do not select host boot lets the core run right after the strap cycle.
    // Strap A low differs from host boot in one bit only, so the decode is exercised.
    task automatic t_reset();
        logic [15:0] d;
        @(posedge clk);
        {rst, boot} <= {1'b1, 3'b100};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 check("halt strap cycle", 1, halt);
        @(posedge clk);
        #1 check("halt released", 0, halt);
        check("overlay cleared", HMP_OVERLAY_RST, ovl);
        core_rd(HMP_START_ADDR_OFS, d);
        check("start cleared", HMP_START_ADDR_RST, d);
        $display("t_reset done");
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Tests need a few hundred cycles; the watchdog allows far more.
    initial begin
        #100000;
        n_errors++;
        summarize();
    end
    initial begin
        {rst, stall, reg_wr, reg_rd, boot} <= {4'b1000, HMP_BOOT_HOST};
        {reg_addr, reg_wdata} <= '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_boot();
        t_regs();
        t_dm();
        t_ctrl();
        t_fifo();
        t_reset();
        check("host timeouts", 0, hmp_host_model_i.n_late);
        summarize();
    end
endmodule
`default_nettype wire
